/* verilog/frc_flash_read_controller.sv */
// Flash read controller: system bus read path, commands and status
// Function
// R1 - With zero wait states, one addressed word returned each cycle, no stall.
// R2 - Array read 64 bits at a time, both words of the doubleword fetched.
// R3 - Software picks wait states to suit the clock; zero preferred.
// R4 - One wait state: exactly one stall per doubleword fetch; zero: none.
// R5 - Cache hit with cache enabled is served with no stall.
// R6 - User page mapped at byte offset 0x00800000, one page long.
// R7 - Reads between array end and user page return undefined data.
// R8 - Chip erase leaves the user page alone; own commands only.
// R9 - Main array in 16 regions, each locked by its fuse bit.
// R10 - Separate fast read on/off commands; mode shown in status flag.
// R11 - After reset normal read mode, fast read off until enabled.
// R12 - Erased check ANDs every page bit into one status result bit.
// R13 - Write and erase refused while power scaling selection is one.
// R14 - Gated clocks halt everything; work resumes where it stopped.
// R15 - Debug state of the processor changes nothing here.
// R16 - System keeps bus clocks running before any access.
// R17 - Three ports: array read, cache RAM, peripheral commands.
// R18 - Command write clears ready at once; completion sets it again.
// R19 - Completion raises interrupt when enabled, except erased checks.
// R20 - Ready held low during a wait state, released with valid data.
// R21 - Second word buffered; its later read needs no array access.
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/100ps
module frc_flash_read_controller
	import frc_pkg::*;
#(
	parameter int ARRAY_BYTES = 262144,
	parameter int PAGE_BYTES = 256,
	parameter int CRAM_WORDS = 1024
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB register port
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// System bus array read port
	input wire logic hsbValid,
	input wire logic [ADDR_W-1:0] hsbAddr,
	output logic hsbReady,
	output logic [31:0] hsbRdata,
	// Cache lookup
	input wire logic cacheEnable,
	input wire logic cacheHit,
	input wire logic [31:0] cacheRdata,
	// Cache RAM port
	input wire logic cramValid,
	input wire logic cramWrite,
	input wire logic [$clog2(CRAM_WORDS)-1:0] cramAddr,
	input wire logic [31:0] cramWdata,
	output logic [31:0] cramRdata,
	output logic cramError,
	// Flash array
	output logic arrayRd,
	output logic [DWA_W-1:0] arrayDwAddr,
	input wire logic [63:0] arrayData,
	output logic arrayOpReq,
	output logic [2:0] arrayOp,
	output logic [PAGE_W-1:0] arrayOpPage,
	input wire logic arrayOpDone,
	// System status
	input wire logic [LOCK_REGIONS-1:0] lockFuses,
	input wire logic powerScaleSel,
	output logic irq
);
	localparam int PAGES = ARRAY_BYTES / PAGE_BYTES;
	localparam int PDW_SH = $clog2(PAGE_BYTES / 8);
	localparam int RG_SH = $clog2(PAGES / LOCK_REGIONS);

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	logic stall_q, stall_d, holdHi_q, holdHi_d, bufValid_q, bufValid_d;
	logic [DWA_W-1:0] hold_q, hold_d, bufAddr_q, bufAddr_d, chkAddr_q, chkAddr_d;
	logic [63:0] buf_q, buf_d;
	logic [31:0] rdata_q, rdata_d;
	logic ws_q, ws_d, rdyIe_q, rdyIe_d;
	frc_cmd_state_t cs_q, cs_d;
	logic busy, accept, bufHit, cacheSrv, chkSample, opStart;
	logic [DWA_W-1:0] dw;

	assign busy = (cs_q == CS_CHECK) || (cs_q == CS_PROG);
	assign hsbReady = !stall_q && !busy; // [R20]
	assign accept = hsbValid && hsbReady;
	assign dw = hsbAddr[ADDR_W-1:3]; // [R6] [R7]
	assign bufHit = bufValid_q && (bufAddr_q == dw);
	assign cacheSrv = cacheEnable && cacheHit;
	assign arrayRd = (accept && !bufHit && !cacheSrv) || stall_q || (cs_q == CS_CHECK);
	assign arrayDwAddr = (cs_q == CS_CHECK) ? chkAddr_q : (stall_q ? hold_q : dw);
	assign hsbRdata = rdata_q;

	always_comb begin
		stall_d = 1'h0;
		hold_d = hold_q;
		holdHi_d = holdHi_q;
		buf_d = buf_q;
		bufAddr_d = bufAddr_q;
		bufValid_d = bufValid_q && !opStart;
		rdata_d = rdata_q;
		if (stall_q) begin
			rdata_d = holdHi_q ? arrayData[63:32] : arrayData[31:0]; // [R4] [R20]
			buf_d = arrayData; // [R2]
			bufAddr_d = hold_q;
			bufValid_d = 1'h1;
		end else if (accept) begin
			if (cacheSrv) begin
				rdata_d = cacheRdata; // [R5]
			end else if (bufHit) begin
				rdata_d = hsbAddr[2] ? buf_q[63:32] : buf_q[31:0]; // [R21]
			end else if (!ws_q) begin
				rdata_d = hsbAddr[2] ? arrayData[63:32] : arrayData[31:0]; // [R1]
				buf_d = arrayData; // [R2] [R21]
				bufAddr_d = dw;
				bufValid_d = 1'h1;
			end else begin
				stall_d = 1'h1; // [R4]
				hold_d = dw;
				holdHi_d = hsbAddr[2];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			stall_q <= 1'h0;
			hold_q <= '0;
			holdHi_q <= 1'h0;
			buf_q <= 64'h0;
			bufAddr_q <= '0;
			bufValid_q <= 1'h0;
			rdata_q <= 32'h0;
		end else begin
			stall_q <= stall_d;
			hold_q <= hold_d;
			holdHi_q <= holdHi_d;
			buf_q <= buf_d;
			bufAddr_q <= bufAddr_d;
			bufValid_q <= bufValid_d;
			rdata_q <= rdata_d;
		end
	end

	// ------------------------------------------------------------
	// Command sequencer and status
	// ------------------------------------------------------------
	logic [5:0] code_q, code_d;
	logic [PAGE_W-1:0] page_q, page_d;
	logic rdy_q, rdy_d, fast_q, fast_d, page_check_result_q, page_check_result_d, lockE_q, lockE_d;
	logic progE_q, progE_d, irq_q, irq_d, chkWait_q, chkWait_d, opReq_q, opReq_d;
	logic [2:0] op_q, op_d;
	logic [PDW_SH-1:0] chkCnt_q, chkCnt_d;
	logic cmdWr, ctrlWr, isOp, isMainPage;
	logic [3:0] region;

	assign cmdWr = psel && penable && pwrite && (paddr == CMD_OFS);
	assign ctrlWr = psel && penable && pwrite && (paddr == CTRL_OFS);
	assign isOp = (code_q >= CMD_WRITE_PAGE) && (code_q <= CMD_ERASE_CHIP);
	assign isMainPage = (code_q == CMD_WRITE_PAGE) || (code_q == CMD_ERASE_PAGE);
	assign region = 4'(page_q >> RG_SH);
	assign opStart = (cs_q == CS_PEND) && !hsbValid && !stall_q && isOp && !powerScaleSel
		&& !(isMainPage && lockFuses[region]);
	assign chkSample = !ws_q || chkWait_q;

	always_comb begin
		cs_d = cs_q;
		code_d = code_q;
		page_d = page_q;
		rdy_d = rdy_q;
		fast_d = fast_q;
		page_check_result_d = page_check_result_q;
		lockE_d = lockE_q;
		progE_d = progE_q;
		irq_d = irq_q;
		chkAddr_d = chkAddr_q;
		chkCnt_d = chkCnt_q;
		chkWait_d = 1'h0;
		opReq_d = 1'h0;
		op_d = op_q;
		ws_d = ctrlWr ? pwdata[CTRL_WS_BIT] : ws_q; // [R3]
		rdyIe_d = ctrlWr ? pwdata[CTRL_RDYIE_BIT] : rdyIe_q;
		case (cs_q)
			CS_IDLE: begin
				if (cmdWr) begin
					code_d = pwdata[CMD_CODE_LSB +: 6];
					page_d = pwdata[CMD_PAGE_LSB +: PAGE_W];
					rdy_d = 1'h0; // [R18]
					irq_d = 1'h0;
					lockE_d = 1'h0;
					progE_d = 1'h0;
					cs_d = CS_PEND;
				end
			end
			CS_PEND: begin
				if (!hsbValid && !stall_q) begin
					cs_d = CS_IDLE;
					rdy_d = 1'h1; // [R18]
					irq_d = rdyIe_q; // [R19]
					case (code_q)
						CMD_FAST_ON: fast_d = 1'h1; // [R10] [R11]
						CMD_FAST_OFF: fast_d = 1'h0; // [R10]
						CMD_PAGE_CHECK, CMD_USER_CHECK: begin
							chkAddr_d = (code_q == CMD_USER_CHECK) ? USER_PAGE_OFS[ADDR_W-1:3]
								: DWA_W'(page_q) << PDW_SH; // [R12]
							chkCnt_d = '0;
							page_check_result_d = 1'h1;
							rdy_d = 1'h0;
							irq_d = 1'h0;
							cs_d = CS_CHECK;
						end
						default: begin
							if (isOp && powerScaleSel) begin
								progE_d = 1'h1; // [R13]
							end else if (isOp && isMainPage && lockFuses[region]) begin
								lockE_d = 1'h1; // [R9]
							end else if (isOp) begin
								opReq_d = 1'h1; // [R8]
								op_d = code_q[2:0];
								rdy_d = 1'h0;
								irq_d = 1'h0;
								cs_d = CS_PROG;
							end
						end
					endcase
				end
			end
			CS_CHECK: begin
				chkWait_d = !chkSample;
				if (chkSample) begin
					page_check_result_d = page_check_result_q && (&arrayData); // [R12]
					chkAddr_d = chkAddr_q + DWA_W'(1);
					chkCnt_d = chkCnt_q + PDW_SH'(1);
					if (&chkCnt_q) begin
						rdy_d = 1'h1;
						cs_d = CS_IDLE; // [R19]
					end
				end
			end
			CS_PROG: begin
				if (arrayOpDone) begin
					rdy_d = 1'h1; // [R18]
					irq_d = rdyIe_q; // [R19]
					cs_d = CS_IDLE;
				end
			end
			default: cs_d = CS_IDLE;
		endcase
	end

	// Only reset and the clock act here: a gated clock freezes all state
	always_ff @(posedge clk) begin // [R14] [R15]
		if (rst) begin
			cs_q <= CS_IDLE;
			code_q <= 6'h0;
			page_q <= '0;
			rdy_q <= 1'h1;
			fast_q <= RESET_FAST; // [R11]
			page_check_result_q <= 1'h0;
			lockE_q <= 1'h0;
			progE_q <= 1'h0;
			irq_q <= 1'h0;
			chkAddr_q <= '0;
			chkCnt_q <= '0;
			chkWait_q <= 1'h0;
			opReq_q <= 1'h0;
			op_q <= 3'h0;
			ws_q <= RESET_WS;
			rdyIe_q <= RESET_RDYIE;
		end else begin
			cs_q <= cs_d;
			code_q <= code_d;
			page_q <= page_d;
			rdy_q <= rdy_d;
			fast_q <= fast_d;
			page_check_result_q <= page_check_result_d;
			lockE_q <= lockE_d;
			progE_q <= progE_d;
			irq_q <= irq_d;
			chkAddr_q <= chkAddr_d;
			chkCnt_q <= chkCnt_d;
			chkWait_q <= chkWait_d;
			opReq_q <= opReq_d;
			op_q <= op_d;
			ws_q <= ws_d;
			rdyIe_q <= rdyIe_d;
		end
	end

	assign arrayOpReq = opReq_q;
	assign arrayOp = op_q;
	assign arrayOpPage = page_q;
	assign irq = irq_q;

	// ------------------------------------------------------------
	// APB read mux and cache RAM port
	// ------------------------------------------------------------
	always_comb begin
		prdata = 32'h0;
		case (paddr)
			CTRL_OFS: begin
				prdata[CTRL_WS_BIT] = ws_q;
				prdata[CTRL_RDYIE_BIT] = rdyIe_q;
			end
			CMD_OFS: begin
				prdata[CMD_CODE_LSB +: 6] = code_q;
				prdata[CMD_PAGE_LSB +: PAGE_W] = page_q;
			end
			STATUS_OFS: begin
				prdata[ST_RDY_BIT] = rdy_q;
				prdata[ST_LOCKE_BIT] = lockE_q;
				prdata[ST_PROGE_BIT] = progE_q;
				prdata[ST_FAST_BIT] = fast_q; // [R10]
				prdata[ST_PAGE_CHECK_RESULT_BIT] = page_check_result_q; // [R12]
			end
			default: prdata = 32'h0;
		endcase
	end
	assign pready = 1'h1;
	assign pslverr = psel && penable && (paddr != CTRL_OFS) && (paddr != CMD_OFS)
		&& (paddr != STATUS_OFS);

	frc_cache_ram #(.WORDS(CRAM_WORDS)) uCram ( // [R17]
		.clk(clk),
		.rst(rst),
		.reqValid(cramValid),
		.reqWrite(cramWrite),
		.reqAddr(cramAddr),
		.reqWdata(cramWdata),
		.blocked(cacheEnable),
		.rspRdata(cramRdata),
		.rspError(cramError)
	);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	logic [31:0] stallWord;
	assign stallWord = holdHi_q ? arrayData[63:32] : arrayData[31:0];

	sequence s_missOneWs;
		accept && !bufHit && !cacheSrv && ws_q;
	endsequence
	sequence s_stallThenData;
		!hsbReady ##1 hsbReady;
	endsequence
	property p_zeroWs;
		accept && !ws_q |=> hsbReady;
	endproperty
	a_zeroWs: assert property (p_zeroWs) else $error("zero wait read stalled"); // [R1]
	property p_oneWs;
		s_missOneWs |=> s_stallThenData;
	endproperty
	a_oneWs: assert property (p_oneWs) else $error("one wait read not one stall"); // [R4]
	property p_cacheHit;
		accept && cacheSrv |=> hsbReady && (hsbRdata == $past(cacheRdata));
	endproperty
	a_cacheHit: assert property (p_cacheHit) else $error("cache hit stalled"); // [R5]
	property p_fetch64;
		accept && !bufHit && !cacheSrv && !ws_q |=> buf_q == $past(arrayData) && bufValid_q;
	endproperty
	a_fetch64: assert property (p_fetch64) else $error("doubleword not kept"); // [R2]
	property p_bufHit;
		accept && bufHit && !cacheSrv && !hsbAddr[2] |=> hsbReady && hsbRdata == buf_q[31:0];
	endproperty
	a_bufHit: assert property (p_bufHit) else $error("buffered word miss"); // [R21]
	property p_cmdClr;
		cmdWr && cs_q == CS_IDLE |=> !rdy_q;
	endproperty
	a_cmdClr: assert property (p_cmdClr) else $error("ready not cleared"); // [R18]
	property p_resetMode;
		$fell(rst) |-> !fast_q && rdy_q;
	endproperty
	a_resetMode: assert property (p_resetMode) else $error("fast read on at reset"); // [R11]
	property p_fastOn;
		cs_q == CS_PEND && !hsbValid && !stall_q && code_q == CMD_FAST_ON |=> fast_q && rdy_q;
	endproperty
	a_fastOn: assert property (p_fastOn) else $error("fast read flag not set"); // [R10]
	property p_psRefuse;
		cs_q == CS_PEND && !hsbValid && !stall_q && isOp && powerScaleSel
			|=> progE_q && !arrayOpReq && cs_q == CS_IDLE;
	endproperty
	a_psRefuse: assert property (p_psRefuse) else $error("write under scaling"); // [R13]
	property p_lock;
		cs_q == CS_PEND && !hsbValid && !stall_q && isMainPage && lockFuses[region]
			|=> !arrayOpReq;
	endproperty
	a_lock: assert property (p_lock) else $error("locked region modified"); // [R9]
	property p_checkNoIrq;
		cs_q == CS_CHECK |=> !irq;
	endproperty
	a_checkNoIrq: assert property (p_checkNoIrq) else $error("irq on erased check"); // [R19]
	property p_waitLow;
		stall_q |-> !hsbReady ##1 hsbRdata == $past(stallWord);
	endproperty
	a_waitLow: assert property (p_waitLow) else $error("wait state data wrong"); // [R20]
endmodule : frc_flash_read_controller

/* verilog/frc_pkg.sv */
// Shared constants and types for the flash read controller
package frc_pkg;

	// ------------------------------------------------------------
	// Register offsets (byte addresses on APB)
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] CMD_OFS = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h08;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int CTRL_WS_BIT = 0;
	localparam int CTRL_RDYIE_BIT = 1;
	localparam int CMD_CODE_LSB = 0;
	localparam int CMD_PAGE_LSB = 8;
	localparam int ST_RDY_BIT = 0;
	localparam int ST_LOCKE_BIT = 2;
	localparam int ST_PROGE_BIT = 3;
	localparam int ST_FAST_BIT = 4;
	localparam int ST_PAGE_CHECK_RESULT_BIT = 5;
	localparam logic RESET_WS = 1'h0;
	localparam logic RESET_RDYIE = 1'h0;
	localparam logic RESET_FAST = 1'h0;

	// ------------------------------------------------------------
	// Memory map
	// ------------------------------------------------------------
	localparam int ADDR_W = 24;
	localparam int DWA_W = ADDR_W - 3;
	localparam logic [ADDR_W-1:0] USER_PAGE_OFS = 24'h80_0000;
	localparam int LOCK_REGIONS = 16;
	localparam int PAGE_W = 16;

	// ------------------------------------------------------------
	// Commands and array operations
	// ------------------------------------------------------------
	localparam logic [5:0] CMD_WRITE_PAGE = 6'h01;
	localparam logic [5:0] CMD_ERASE_PAGE = 6'h02;
	localparam logic [5:0] CMD_WRITE_USER = 6'h03;
	localparam logic [5:0] CMD_ERASE_USER = 6'h04;
	localparam logic [5:0] CMD_ERASE_CHIP = 6'h05;
	localparam logic [5:0] CMD_PAGE_CHECK = 6'h0c;
	localparam logic [5:0] CMD_USER_CHECK = 6'h0f;
	localparam logic [5:0] CMD_FAST_ON = 6'h10;
	localparam logic [5:0] CMD_FAST_OFF = 6'h11;

	typedef enum logic [2:0] {
		OP_WRITE_PAGE = 3'b001,
		OP_ERASE_PAGE = 3'b010,
		OP_WRITE_USER = 3'b011,
		OP_ERASE_USER = 3'b100,
		OP_ERASE_CHIP = 3'b101
	} frc_op_t;

	typedef enum logic [1:0] {
		CS_IDLE = 2'b00,
		CS_PEND = 2'b01,
		CS_CHECK = 2'b10,
		CS_PROG = 2'b11
	} frc_cmd_state_t;

endpackage : frc_pkg

/* verilog/frc_cache_ram.sv */
// Cache RAM reachable as plain memory while the cache is off
`timescale 1ns/100ps
module frc_cache_ram #(
	parameter int WORDS = 1024,
	parameter int AW = $clog2(WORDS)
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Access port
	input wire logic reqValid,
	input wire logic reqWrite,
	input wire logic [AW-1:0] reqAddr,
	input wire logic [31:0] reqWdata,
	input wire logic blocked,
	output logic [31:0] rspRdata,
	output logic rspError
);
	logic [31:0] mem [WORDS];
	logic [31:0] rdata_q, rdata_d;
	logic error_q, error_d;

	always_comb begin
		rdata_d = rdata_q;
		error_d = reqValid && blocked;
		if (reqValid && !blocked && !reqWrite) begin
			rdata_d = mem[reqAddr];
		end
	end

	always_ff @(posedge clk) begin
		if (reqValid && !blocked && reqWrite) begin
			mem[reqAddr] <= reqWdata;
		end
		if (rst) begin
			rdata_q <= 32'h0;
			error_q <= 1'h0;
		end else begin
			rdata_q <= rdata_d;
			error_q <= error_d;
		end
	end

	assign rspRdata = rdata_q;
	assign rspError = error_q;
endmodule : frc_cache_ram

/* tb/frc_array_model.sv */
// Flash array model answering doubleword reads and array operations
`timescale 1ns/100ps
module frc_array_model #(
	parameter int ERASED_PG = 3,
	parameter int DONE_LAT = 6
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Array side
	input wire logic arrayRd,
	input wire logic [20:0] arrayDwAddr,
	output logic [63:0] arrayData,
	input wire logic arrayOpReq,
	output logic arrayOpDone
);
	logic [23:0] byteA;
	int cnt;
	assign byteA = {arrayDwAddr, 3'h0};
	// Erased page reads all ones; an idle array shows the inverse
	always_comb begin
		if (byteA[23:6] == 18'(ERASED_PG))
			arrayData = '1;
		else
			arrayData = {8'h5a, byteA + 24'h4, 8'h5a, byteA};
		if (arrayRd !== 1'b1)
			arrayData = ~arrayData;
	end
	// Operation done pulse DONE_LAT cycles after the request
	always @(posedge clk) begin
		arrayOpDone <= 1'b0;
		if (rst)
			cnt <= 0;
		else if (arrayOpReq === 1'b1)
			cnt <= DONE_LAT;
		else if (cnt > 0) begin
			cnt <= cnt - 1;
			arrayOpDone <= (cnt == 1);
		end
	end
endmodule : frc_array_model

/* tb/frc_flash_read_controller_tb.sv */
// Testbench for the flash read controller
`timescale 1ns/100ps
module frc_flash_read_controller_tb
	import frc_pkg::*;
();
	localparam logic [31:0] CWORD = 32'hcafe0001;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic pready, pslverr, perr, firstRdy, hsbValid = 1'b0, hsbReady;
	logic cacheEnable = 1'b0, cacheHit = 1'b0, cramValid = 1'b0, cramWrite = 1'b0;
	logic cramError, arrayRd, arrayOpReq, arrayOpDone, powerScaleSel = 1'b0, irq;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = '0, prdata, hsbRdata, cramRdata, cramWdata = '0, rd;
	logic [23:0] hsbAddr = '0;
	logic [3:0] cramAddr = '0;
	logic [20:0] arrayDwAddr;
	logic [63:0] arrayData;
	logic [2:0] arrayOp;
	logic [15:0] arrayOpPage, lockFuses = '0;
	int fails = 0, total_checks = 0, opReqs = 0, n0;

	always #50 clk = ~clk;
	always @(posedge clk) if (arrayOpReq === 1'b1) opReqs++;

	frc_flash_read_controller #(.ARRAY_BYTES(4096), .PAGE_BYTES(64), .CRAM_WORDS(16)) dut (
		.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .hsbValid, .hsbAddr, .hsbReady, .hsbRdata, .cacheEnable, .cacheHit,
		.cacheRdata(CWORD), .cramValid, .cramWrite, .cramAddr, .cramWdata, .cramRdata,
		.cramError, .arrayRd, .arrayDwAddr, .arrayData, .arrayOpReq, .arrayOp,
		.arrayOpPage, .arrayOpDone, .lockFuses, .powerScaleSel, .irq);
	frc_array_model u_mem (.clk, .rst, .arrayRd, .arrayDwAddr, .arrayData, .arrayOpReq,
		.arrayOpDone);

	// --------------------
	// Tasks
	// --------------------
	function automatic logic [31:0] expw(input logic [23:0] a);
		if (a[23:6] == 18'd3)
			return 32'hffffffff;
		return {8'h5a, a[23:2], 2'b00};
	endfunction : expw

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		chk("pready", 32'h1, pready);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic cmd(input logic [5:0] c, input logic [15:0] pg);
		int n;
		n = 0;
		apb(1'b1, CMD_OFS, {8'h00, pg, 2'b00, c});
		apb(1'b0, STATUS_OFS, 32'h0);
		firstRdy = rd[ST_RDY_BIT];
		while (rd[ST_RDY_BIT] !== 1'b1 && n < 100) begin
			apb(1'b0, STATUS_OFS, 32'h0);
			n++;
		end
		chk("ready", 32'h1, rd[ST_RDY_BIT]);
	endtask : cmd

	task automatic cram(input logic w, input logic [3:0] a, input logic [31:0] d);
		cramValid <= 1'b1;
		cramWrite <= w;
		cramAddr <= a;
		cramWdata <= d;
		@(posedge clk);
		cramValid <= 1'b0;
		@(posedge clk);
	endtask : cram

	// Pipelined reads: n words from a0, stalls and array read cycles counted
	task automatic burst(input logic [23:0] a0, input int n, input logic hit, input int eStall,
		input int eRd);
		int sent, got, stalls, rds, g;
		logic pend;
		logic [23:0] pa;
		sent = 1;
		got = 0;
		stalls = 0;
		rds = 0;
		g = 0;
		pend = 1'b0;
		pa = a0;
		hsbValid <= 1'b1;
		hsbAddr <= a0;
		while (got < n && g < 200) begin
			@(posedge clk);
			g++;
			rds += int'(arrayRd === 1'b1);
			if (hsbReady !== 1'b1)
				stalls++;
			else begin
				if (pend) begin
					chk("hsbRdata", hit ? CWORD : expw(pa), hsbRdata);
					got++;
				end
				pend = hsbValid;
				pa = hsbAddr;
				if (hsbValid && sent < n) begin
					hsbAddr <= hsbAddr + 24'h4;
					sent++;
				end else
					hsbValid <= 1'b0;
			end
		end
		chk("words", n, got);
		chk("stalls", eStall, stalls);
		chk("arrayRd cycles", eRd, rds);
	endtask : burst

	task end_of_test;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_of_test

	// --------------------
	// Tests
	// --------------------
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		apb(1'b0, CTRL_OFS, 32'h0);
		chk("ctrl", 32'h0, rd);
		apb(1'b0, STATUS_OFS, 32'h0);
		chk("status", 32'h1, rd & 32'h3d);
		apb(1'b0, 8'h0c, 32'h0);
		chk("pslverr", 32'h1, perr);
		$display("test reset finished");
		burst(24'h4, 5, 1'b0, 0, 3);
		burst(24'h10, 1, 1'b0, 0, 0);
		apb(1'b1, CTRL_OFS, 32'h1);
		burst(24'h100, 6, 1'b0, 3, 6);
		cacheEnable <= 1'b1;
		cacheHit <= 1'b1;
		burst(24'h200, 2, 1'b1, 0, 0);
		cram(1'b0, 4'h3, 32'h0);
		chk("cramError", 32'h1, cramError);
		cacheEnable <= 1'b0;
		cacheHit <= 1'b0;
		cram(1'b1, 4'h3, 32'h1234);
		cram(1'b0, 4'h3, 32'h0);
		chk("cramRdata", 32'h1234, cramRdata);
		apb(1'b1, CTRL_OFS, 32'h0);
		burst(24'h800000, 2, 1'b0, 0, 1);
		$display("test reads finished");
		apb(1'b1, CTRL_OFS, 32'h2);
		cmd(CMD_FAST_ON, 16'h0);
		chk("fast flag", 32'h1, rd[ST_FAST_BIT]);
		chk("irq", 32'h1, irq);
		cmd(CMD_FAST_OFF, 16'h0);
		chk("fast flag", 32'h0, rd[ST_FAST_BIT]);
		cmd(CMD_PAGE_CHECK, 16'h3);
		chk("first ready", 32'h0, firstRdy);
		chk("check result", 32'h1, rd[ST_PAGE_CHECK_RESULT_BIT]);
		chk("irq", 32'h0, irq);
		cmd(CMD_PAGE_CHECK, 16'h1);
		chk("check result", 32'h0, rd[ST_PAGE_CHECK_RESULT_BIT]);
		cmd(CMD_USER_CHECK, 16'h0);
		chk("irq", 32'h0, irq);
		chk("check result", 32'h0, rd[ST_PAGE_CHECK_RESULT_BIT]);
		for (int i = 1; i <= 5; i++) begin
			n0 = opReqs;
			cmd(6'(i), 16'h5);
			chk("first ready", 32'h0, firstRdy);
			chk("op requests", n0 + 1, opReqs);
			chk("array op", i, arrayOp);
			chk("irq", 32'h1, irq);
			if (i < 3)
				chk("op page", 32'h5, arrayOpPage);
		end
		lockFuses <= 16'h0002;
		n0 = opReqs;
		cmd(CMD_WRITE_PAGE, 16'h5);
		chk("lock error", 32'h1, rd[ST_LOCKE_BIT]);
		chk("op requests", n0, opReqs);
		cmd(CMD_ERASE_PAGE, 16'h9);
		chk("op requests", n0 + 1, opReqs);
		powerScaleSel <= 1'b1;
		cmd(CMD_ERASE_PAGE, 16'h9);
		chk("scaling error", 32'h1, rd[ST_PROGE_BIT]);
		chk("op requests", n0 + 1, opReqs);
		$display("test commands finished");
		end_of_test;
	end

	// Watchdog, over twenty times the expected run
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		end_of_test;
	end
endmodule : frc_flash_read_controller_tb
